/* rtl/spi_consts.svh */
// Purpose: Constants for the shortest-path indexer command logic.
// Assumes: 50 MHz clock.
// Notes: Times are in their own unit; cycle counts derive from them.
`ifndef SPI_CONSTS_SVH
`define SPI_CONSTS_SVH
`define SPI_CLK_HZ 50000000
`define SPI_CTRL_MODE_INDEXER 4'h8
`define SPI_SPEED_SRC_TABLE 4'h0
`define SPI_WARN_HOME_INCOMPLETE 8'h90
`define SPI_STA_W 8
`define SPI_TBL_W 16
`define SPI_TQ_W 16
`define SPI_DLY_W 16
`define SPI_POS_W 16
`define SPI_DELAY_UNIT_US 1000
`define SPI_CYC_PER_MS ((`SPI_CLK_HZ / 1000))
`endif

/* rtl/spi_pkg.sv */
// Purpose: Types shared by the indexer command logic.
// Assumes: Constants header included.
// Notes: Carriers are packed structs.
`include "spi_consts.svh"
package spi_pkg;
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_MOVE = 2'b01,
        SPI_HOLD = 2'b10
    } spi_state_type;

    typedef struct packed {
        logic [`SPI_TQ_W-1:0] fwd;
        logic [`SPI_TQ_W-1:0] rev;
        logic [`SPI_TQ_W-1:0] stop;
        logic [`SPI_DLY_W-1:0] delay_ms;
    } spi_torque_cfg_type;

    typedef struct packed {
        logic valid;
        logic dir_ccw;
        logic [`SPI_STA_W-1:0] station;
        logic [`SPI_TBL_W-1:0] table_sel;
    } spi_move_cmd_type;
endpackage

/* rtl/spi_ms_tick.sv */
// Purpose: One-cycle pulse every millisecond for the torque delay.
// Assumes: 50 MHz clock.
// Notes: Restart aligns the first tick one full millisecond after it.
`timescale 1ns/100ps
`include "spi_consts.svh"
module spi_ms_tick (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic restart, // Clears the prescaler.
    output logic tick // One-cycle millisecond pulse.
);
    localparam int unsigned DIV = `SPI_CYC_PER_MS;
    logic [15:0] cnt_reg;
    wire last = (cnt_reg == 16'(DIV - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
        end else if (restart || last) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
    assign tick = last && !restart;
endmodule // spi_ms_tick

/* rtl/spi_indexer.sv */
// What this block does
// - A start edge begins a move to the chosen station with the chosen table's profile.
// - Start selects the run torque limit; stop limit returns a set delay after completion.
// - A start without home return raises warning 90 and is ignored.
// - Equal distances either way rotate toward increasing station number.
// - A start during a move or its stop-limit delay is ignored; the master waits for that delay to end first.
// - After reset, in-position turns on if droop lies within a station's in-position range.
//
// Purpose: Command logic for shortest-rotation indexer moves with table speed.
// Assumes: Profile generator outside executes move_cmd and reports motion_done.
// Notes: Inputs are synchronous to clk; the number of stations comes from a port.
// The hold delay is read live, so changing it during a hold moves the end of that hold.
// A station count of zero gives meaningless distances; the master must set it first.
`timescale 1ns/100ps
`include "spi_consts.svh"
module spi_indexer
    import spi_pkg::*;
(
    input wire logic clk, // 50 MHz clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [3:0] control_mode_param, // Control mode setting.
    input wire logic specifying_method_select_bit, // Position/speed method on.
    input wire logic [3:0] speed_source_param, // Speed source setting.
    input wire logic op_mode_select_one, // Operation mode bit one.
    input wire logic op_mode_select_two, // Operation mode bit two.
    input wire logic start_bit, // Start request level.
    input wire logic [`SPI_STA_W-1:0] next_station_word, // Target station.
    input wire logic [`SPI_TBL_W-1:0] table_or_speed_low_word, // Point table number.
    input wire logic [`SPI_STA_W-1:0] station_count, // Number of stations.
    input wire logic [`SPI_STA_W-1:0] current_station, // Station the shaft is at.
    input wire logic home_done, // Home position return complete.
    input wire logic motion_done, // Profile generator reached target.
    input wire logic [`SPI_POS_W-1:0] droop_pulses, // Absolute droop count.
    input wire logic [`SPI_POS_W-1:0] in_position_range, // In-position range.
    input wire logic [`SPI_TQ_W-1:0] forward_torque_limit_param, // Run limit forward.
    input wire logic [`SPI_TQ_W-1:0] reverse_torque_limit_param, // Run limit reverse.
    input wire logic [`SPI_TQ_W-1:0] stop_torque_limit_param, // Limit while stopped.
    input wire logic [`SPI_DLY_W-1:0] torque_limit_switch_delay_param, // Delay in ms.
    output spi_move_cmd_type move_cmd, // Move request to profile generator.
    output logic [`SPI_TQ_W-1:0] torque_limit, // Active torque limit.
    output logic travel_complete_flag, // Travel completion.
    output logic in_position_flag, // In-position.
    output logic home_incomplete_warning, // Warning active.
    output logic [7:0] warning_code // Warning number when active.
);
    spi_state_type state_reg, state_next;
    spi_move_cmd_type cmd_reg;
    logic start_d_reg;
    logic complete_reg;
    logic inpos_reg;
    logic warn_reg;
    logic [7:0] code_reg;
    logic [`SPI_TQ_W-1:0] tq_reg;
    logic [`SPI_DLY_W-1:0] dly_reg;
    logic ms_tick;

    // Distance going up the station numbers, modulo the station count.
    function automatic logic [`SPI_STA_W-1:0] fwd_dist(
        input logic [`SPI_STA_W-1:0] from_sta,
        input logic [`SPI_STA_W-1:0] to_sta,
        input logic [`SPI_STA_W-1:0] count
    );
        logic [`SPI_STA_W:0] d;
        d = {1'b0, to_sta} - {1'b0, from_sta};
        if (to_sta < from_sta) begin
            d = d + {1'b0, count};
        end
        return d[`SPI_STA_W-1:0];
    endfunction

    // Mode gating: wrong setup means starts are not acted upon.
    // Mode bits are read live, so a mode change during a move does not stop that move.
    wire mode_ok = (control_mode_param == `SPI_CTRL_MODE_INDEXER)
        && specifying_method_select_bit
        && (speed_source_param == `SPI_SPEED_SRC_TABLE)
        && op_mode_select_one && op_mode_select_two;
    // Start is a level; only its rising edge counts, so a start held through a refusal
    // never fires late once the refusal ends.
    wire start_edge = start_bit && !start_d_reg;
    wire in_idle = (state_reg == SPI_IDLE);
    wire start_req = start_edge && mode_ok;
    wire start_go = start_req && home_done && in_idle;
    wire start_noh = start_req && !home_done;

    wire [`SPI_STA_W-1:0] up_d = fwd_dist(current_station, next_station_word, station_count);
    wire [`SPI_STA_W-1:0] dn_d = fwd_dist(next_station_word, current_station, station_count);
    // Ties go upward, so only a strictly shorter downward path turns CCW.
    wire go_down = (dn_d < up_d);
    // The run limit follows the direction that the move will take.
    wire [`SPI_TQ_W-1:0] run_limit = go_down ? reverse_torque_limit_param
        : forward_torque_limit_param;

    wire delay_over = (dly_reg == torque_limit_switch_delay_param);
    wire hold_done = (state_reg == SPI_HOLD) && delay_over;
    // The prescaler is cleared outside the hold so the first millisecond is a full one.
    wire tick_restart = (state_reg != SPI_HOLD);
    wire droop_ok = (droop_pulses <= in_position_range);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SPI_IDLE: begin
                if (start_go) begin
                    state_next = SPI_MOVE;
                end
            end
            SPI_MOVE: begin
                // Completion comes only from the profile generator; no timeout is kept here.
                if (motion_done) begin
                    state_next = SPI_HOLD;
                end
            end
            SPI_HOLD: begin
                if (delay_over) begin
                    state_next = SPI_IDLE;
                end
            end
            default: begin
                state_next = SPI_IDLE;
            end
        endcase
    end

    spi_ms_tick u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .restart(tick_restart),
        .tick(ms_tick)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SPI_IDLE;
            start_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_d_reg <= start_bit;
        end
    end

    // Command latched at start; table changes mid-move have no effect.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= '0;
        end else if (start_go) begin
            cmd_reg <= '{valid: 1'b1, dir_ccw: go_down, station: next_station_word,
                table_sel: table_or_speed_low_word};
        end else begin
            cmd_reg.valid <= 1'b0;
        end
    end

    // Completion drops on an accepted start and rises when motion ends.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            complete_reg <= 1'b0;
        end else if (start_go) begin
            complete_reg <= 1'b0;
        end else if (state_reg == SPI_MOVE && motion_done) begin
            complete_reg <= 1'b1;
        end
    end

    // In-position is droop-based, so it also holds straight after reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inpos_reg <= 1'b0;
        end else begin
            inpos_reg <= (state_reg != SPI_MOVE) && droop_ok;
        end
    end

    // Warning is sticky until home return is reported done; set and clear never meet.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_reg <= 1'b0;
            code_reg <= 8'h00;
        end else if (start_noh) begin
            warn_reg <= 1'b1;
            code_reg <= `SPI_WARN_HOME_INCOMPLETE;
        end else if (home_done) begin
            warn_reg <= 1'b0;
            code_reg <= 8'h00;
        end
    end

    // Torque limit: stop value until start, run value until delay after completion.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tq_reg <= '0;
        end else if (start_go) begin
            tq_reg <= run_limit;
        end else if (in_idle || hold_done) begin
            tq_reg <= stop_torque_limit_param;
        end
    end

    // Hold timer counts whole milliseconds after completion and rests at zero elsewhere.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_reg <= '0;
        end else if (state_reg != SPI_HOLD) begin
            dly_reg <= '0;
        end else if (ms_tick && !delay_over) begin
            dly_reg <= dly_reg + 16'h0001;
        end
    end

    // Every output is a register copy, so none follows an input within the same cycle.
    assign move_cmd = cmd_reg;
    assign torque_limit = tq_reg;
    assign travel_complete_flag = complete_reg;
    assign in_position_flag = inpos_reg;
    assign home_incomplete_warning = warn_reg;
    assign warning_code = code_reg;
endmodule // spi_indexer

/* verif/spi_indexer_checker.sv */
// Purpose: Port-level assertions for the indexer command logic.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: A shadow busy bit tracks moves between command and completion.
`timescale 1ns/100ps
`include "spi_consts.svh"
module spi_indexer_checker
    import spi_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic start_bit, // Start.
    input wire logic home_done, // Homed.
    input wire logic motion_done, // Motion end.
    input wire logic [`SPI_POS_W-1:0] droop_pulses, // Droop.
    input wire logic [`SPI_POS_W-1:0] in_position_range, // Range.
    input wire logic [`SPI_TQ_W-1:0] forward_torque_limit_param, // Fwd limit.
    input wire logic [`SPI_TQ_W-1:0] reverse_torque_limit_param, // Rev limit.
    input wire spi_move_cmd_type move_cmd, // Command.
    input wire logic [`SPI_TQ_W-1:0] torque_limit, // Limit.
    input wire logic travel_complete_flag, // Complete.
    input wire logic in_position_flag, // In position.
    input wire logic home_incomplete_warning, // Warning.
    input wire logic [7:0] warning_code // Code.
);
    logic busy_reg;
    wire in_rng = droop_pulses <= in_position_range;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= move_cmd.valid | (busy_reg & ~travel_complete_flag);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    valid_pulse_a: assert property (
        move_cmd.valid |=> !move_cmd.valid) else $error("valid too long");
    run_limit_a: assert property (
        move_cmd.valid |-> torque_limit == (move_cmd.dir_ccw ?
        reverse_torque_limit_param : forward_torque_limit_param)) else $error("run limit wrong");
    fresh_move_a: assert property (
        move_cmd.valid |-> !travel_complete_flag) else $error("complete stuck");
    warn_code_a: assert property (
        home_incomplete_warning |-> warning_code == 8'h90) else $error("bad code");
    unhomed_start_a: assert property (
        $rose(start_bit) && !home_done |=> !move_cmd.valid [*2]) else $error("unhomed move");
    busy_ignore_a: assert property (
        busy_reg && $rose(start_bit) |=> !move_cmd.valid [*2]) else $error("busy start taken");
    done_flag_a: assert property (
        busy_reg && motion_done && !travel_complete_flag |=> travel_complete_flag)
        else $error("no completion");
    in_pos_a: assert property (
        !busy_reg && !move_cmd.valid && !$rose(start_bit) |=> in_position_flag == $past(in_rng))
        else $error("in-position wrong");
    cover property (move_cmd.valid && move_cmd.dir_ccw);
    cover property (busy_reg && motion_done);
    cover property (busy_reg && $rose(start_bit));
    cover property (home_incomplete_warning);
endmodule // spi_indexer_checker
bind spi_indexer spi_indexer_checker chk_u (.clk, .rst_n, .start_bit, .home_done, .motion_done,
    .droop_pulses, .in_position_range, .forward_torque_limit_param, .reverse_torque_limit_param,
    .move_cmd, .torque_limit, .travel_complete_flag, .in_position_flag,
    .home_incomplete_warning, .warning_code);

/* verif/spi_master_model.sv */
// Purpose: Network master writing the mode bits, words and start.
// Assumes: Bench calls its tasks; changes land 1 ns after an edge.
// Notes: HOLD_CYC shortens the mode switching hold to keep runs brief.
`timescale 1ns/100ps
module spi_master_model #(
    parameter int HOLD_CYC = 4
) (
    input wire logic clk, // Clock.
    output logic [3:0] control_mode_param, // Mode.
    output logic specifying_method_select_bit, // Method.
    output logic [3:0] speed_source_param, // Speed source.
    output logic op_mode_select_one, // Op bit one.
    output logic op_mode_select_two, // Op bit two.
    output logic start_bit, // Start.
    output logic [7:0] next_station_word, // Station.
    output logic [15:0] table_or_speed_low_word // Table.
);
    initial begin
        start_bit = 1'b0;
        next_station_word = 8'h00;
        table_or_speed_low_word = 16'h0000;
    end
    // Setting k of zero is correct; 1 to 4 each spoil one selection.
    task automatic set_mode(input int k);
        @(posedge clk);
        #1;
        control_mode_param = (k == 1) ? 4'h3 : 4'h8;
        specifying_method_select_bit = (k != 2);
        speed_source_param = (k == 3) ? 4'h1 : 4'h0;
        op_mode_select_one = 1'b1;
        op_mode_select_two = (k != 4);
        repeat (HOLD_CYC) @(posedge clk);
        #1;
    endtask
    task automatic go(input logic [7:0] sta, input logic [15:0] tbl);
        next_station_word = sta;
        table_or_speed_low_word = tbl;
        @(posedge clk);
        #1;
        start_bit = 1'b1;
    endtask
    task automatic drop();
        start_bit = 1'b0;
    endtask
endmodule // spi_master_model

/* verif/shortest_path_indexer_table_speed_tb.sv */
// Purpose: Self-checking bench for the indexer command logic.
// Assumes: One clock; the bench plays the profile generator.
// Notes: One move uses a 1 ms delay, so the run spans some 50000 cycles.
`timescale 1ns/100ps
`include "spi_consts.svh"
module shortest_path_indexer_table_speed_tb
    import spi_pkg::*;
;
    logic clk, rst_n, home_done, motion_done, travel_complete_flag, in_position_flag;
    logic specifying_method_select_bit, op_mode_select_one, op_mode_select_two, start_bit;
    logic home_incomplete_warning;
    logic [3:0] control_mode_param, speed_source_param;
    logic [7:0] next_station_word, station_count, current_station, warning_code;
    logic [15:0] table_or_speed_low_word, droop_pulses, in_position_range, torque_limit;
    logic [15:0] forward_torque_limit_param, reverse_torque_limit_param;
    logic [15:0] stop_torque_limit_param, torque_limit_switch_delay_param;
    spi_move_cmd_type move_cmd;
    int n_fail, num_checks;
    spi_master_model partner_u (.clk, .control_mode_param, .specifying_method_select_bit,
        .speed_source_param, .op_mode_select_one, .op_mode_select_two, .start_bit,
        .next_station_word, .table_or_speed_low_word);
    spi_indexer dut_u (.clk, .rst_n, .control_mode_param, .specifying_method_select_bit,
        .speed_source_param, .op_mode_select_one, .op_mode_select_two, .start_bit,
        .next_station_word, .table_or_speed_low_word, .station_count, .current_station,
        .home_done, .motion_done, .droop_pulses, .in_position_range, .forward_torque_limit_param,
        .reverse_torque_limit_param, .stop_torque_limit_param, .torque_limit_switch_delay_param,
        .move_cmd, .torque_limit, .travel_complete_flag, .in_position_flag,
        .home_incomplete_warning, .warning_code);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Issues a start and reports whether a command pulse followed, then drops start.
    task automatic try_start(input logic [7:0] sta, input logic [15:0] tbl, output logic seen);
        seen = 1'b0;
        partner_u.go(sta, tbl);
        repeat (3) begin
            @(posedge clk);
            #1;
            if (move_cmd.valid === 1'b1) seen = 1'b1;
        end
        partner_u.drop();
    endtask
    task automatic s_power_on();
        repeat (2) @(posedge clk);
        #1;
        check("in position", in_position_flag, 1);
        check("stop limit", torque_limit, 16'h0033);
        droop_pulses = 16'h0006;
        @(posedge clk);
        #1;
        check("out of position", in_position_flag, 0);
        droop_pulses = 16'h0003;
    endtask
    task automatic s_unhomed();
        logic seen;
        home_done = 1'b0;
        try_start(8'h01, 16'h0001, seen);
        check("unhomed valid", seen, 0);
        check("warning", home_incomplete_warning, 1);
        check("code", warning_code, 16'h0090);
        home_done = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("warning clear", home_incomplete_warning, 0);
        check("code clear", warning_code, 16'h0000);
    endtask
    task automatic s_modes();
        logic seen;
        for (int k = 1; k <= 4; k++) begin
            partner_u.set_mode(k);
            try_start(8'h01, 16'h0001, seen);
            check("bad mode valid", seen, 0);
        end
        partner_u.set_mode(0);
    endtask
    task automatic do_move(input logic [7:0] cur, input logic [7:0] sta, input logic [15:0] tbl,
        input logic ccw);
        logic seen;
        int n;
        int dly_cyc;
        current_station = cur;
        try_start(sta, tbl, seen);
        check("valid", seen, 1);
        check("station", move_cmd.station, sta);
        check("table", move_cmd.table_sel, tbl);
        check("direction", move_cmd.dir_ccw, ccw);
        check("run limit", torque_limit, ccw ? 16'h0222 : 16'h0111);
        try_start(sta, 16'h0009, seen);
        check("busy valid", seen, 0);
        check("table held", move_cmd.table_sel, tbl);
        check("not complete", travel_complete_flag, 0);
        motion_done = 1'b1;
        @(posedge clk);
        #1;
        motion_done = 1'b0;
        @(posedge clk);
        #1;
        check("complete", travel_complete_flag, 1);
        if (torque_limit_switch_delay_param != 16'h0000) begin
            check("held run limit", torque_limit, ccw ? 16'h0222 : 16'h0111);
        end
        dly_cyc = int'(torque_limit_switch_delay_param) * `SPI_CYC_PER_MS;
        n = 0;
        while (n < 60000 && torque_limit !== 16'h0033) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("restored limit", torque_limit, 16'h0033);
        check("hold length", (n + 1 >= dly_cyc) && (n <= dly_cyc + 2), 1);
        if (torque_limit !== 16'h0033) conclude();
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {home_done, motion_done, station_count, current_station} = {2'b10, 8'h08, 8'h00};
        {droop_pulses, in_position_range} = {16'h0003, 16'h0005};
        forward_torque_limit_param = 16'h0111;
        reverse_torque_limit_param = 16'h0222;
        stop_torque_limit_param = 16'h0033;
        torque_limit_switch_delay_param = 16'h0000;
        n_fail = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        s_power_on();
        partner_u.set_mode(0);
        s_unhomed();
        s_modes();
        do_move(8'h00, 8'h02, 16'h0001, 1'b0);
        do_move(8'h02, 8'h07, 16'h0002, 1'b1);
        torque_limit_switch_delay_param = 16'h0001;
        do_move(8'h07, 8'h03, 16'h0001, 1'b0);
        conclude();
    end
endmodule // shortest_path_indexer_table_speed_tb
